// File: core/phyies_flag_bank.sv
// Bank of latched event flags, set by event pulses and cleared per bit
`timescale 1ns/10ps
module phyies_flag_bank #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_clear,
    output logic [WIDTH-1:0] o_flags
);
    import phyies_pkg::*;

    if (WIDTH < 1 || WIDTH > REG_W) begin : g_bad_width
        $error("phyies_flag_bank: WIDTH must be 1 to REG_W");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        if (IMPL_MASK[i]) begin : g_impl
            logic flag_reg;
            logic flag_next;

            // Set wins over clear so an event in the clearing cycle survives
            always_comb begin
                flag_next = (flag_reg & ~i_clear[i]) | i_set[i];
            end

            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    flag_reg <= STATUS_RST[i];
                end else begin
                    flag_reg <= flag_next;
                end
            end

            assign o_flags[i] = flag_reg;
        end else begin : g_rsvd
            assign o_flags[i] = 1'b0;
        end
    end
endmodule : phyies_flag_bank

// File: core/phyies_pkg.sv
// Constants, field layout and bus carriers of the PHY interrupt enable and status block
// Function
// - Quick status bit 1: polarity, resets to 1
// - Quick status bit 0 mirrors jabber, not cleared
// - Interrupt only for enabled, occurred events
// - Bit 15: autonegotiation error enable and flag
// - Bit 14: speed change enable and flag
// - Bit 13: duplex change enable and flag
// - Bit 12: page received enable and flag
// - Bit 11: autonegotiation complete enable and flag
// - Bit 10: link status change enable and flag
// - Bit 8: false carrier enable and flag
// - Bit 6: crossover change enable and flag
// - Enable bits 5-3: downshift, sleep, wake
// - Enable bits 2-0: MAC error, polarity, jabber
// - Flags set even when not enabled
// - Flags latch, cleared by the read returning one
// - Flag bits 5-0 latch the six low events
// - Config bit selects interrupt pin level, reset 1
package phyies_pkg;
    localparam int REG_W = 16;
    localparam int DATA_W = 32;
    localparam int BYTE_SHIFT = 2;
    localparam int IDX_W = 6;
    localparam int AXI_ADDR_W = IDX_W + BYTE_SHIFT;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_QUICK_STATUS = 6'h11;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h12;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h13;
    localparam logic [IDX_W-1:0] IDX_IRQ_CONFIG = 6'h14;

    // Event bit positions, shared by enable and status registers
    localparam int BIT_AN_ERROR = 15;
    localparam int BIT_RATE_CHANGE = 14;
    localparam int BIT_DUPLEX_CHANGE = 13;
    localparam int BIT_PAGE_RECEIVED = 12;
    localparam int BIT_AN_DONE = 11;
    localparam int BIT_LINK_CHANGE = 10;
    localparam int BIT_FALSE_CARRIER = 8;
    localparam int BIT_CROSSOVER_CHANGE = 6;
    localparam int BIT_DOWNSHIFT = 5;
    localparam int BIT_SLEEP_CHANGE = 4;
    localparam int BIT_WAKE_PACKET = 3;
    localparam int BIT_MAC_IF_ERROR = 2;
    localparam int BIT_POLARITY_CHANGE = 1;
    localparam int BIT_JABBER = 0;
    localparam logic [REG_W-1:0] EVENT_IMPL_MASK = 16'hFD7F;

    localparam int QS_BIT_POLARITY = 1;
    localparam int QS_BIT_JABBER = 0;
    localparam int CFG_BIT_IRQ_ACTIVE_LOW = 13;

    localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
    localparam logic [REG_W-1:0] STATUS_RST = 16'h0000;
    localparam logic POLARITY_RST = 1'b1;
    localparam logic JABBER_RST = 1'b0;
    localparam logic IRQ_ACTIVE_LOW_RST = 1'b1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [AXI_ADDR_W-1:0] addr;
        logic [2:0] prot;
    } phyies_addr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DATA_W/8-1:0] strb;
    } phyies_wdata_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0] resp;
    } phyies_rdata_t;
endpackage : phyies_pkg

// File: core/phyies_top.sv
// Interrupt enable, latched event status and quick status registers behind AXI4-Lite
`timescale 1ns/10ps
module phyies_top (
    input wire logic i_clk,
    input wire logic i_rst,
    // Write address channel
    input wire logic i_awvalid,
    output logic o_awready,
    input wire phyies_pkg::phyies_addr_t i_aw,
    // Write data channel
    input wire logic i_wvalid,
    output logic o_wready,
    input wire phyies_pkg::phyies_wdata_t i_w,
    // Write response channel
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // Read address channel
    input wire logic i_arvalid,
    output logic o_arready,
    input wire phyies_pkg::phyies_addr_t i_ar,
    // Read data channel
    output logic o_rvalid,
    input wire logic i_rready,
    output phyies_pkg::phyies_rdata_t o_r,
    // Event sources and line status
    input wire logic [phyies_pkg::REG_W-1:0] i_event_pulse,
    input wire logic i_pol_correct,
    input wire logic i_jabber_detect,
    // Interrupt
    output logic o_irq_pin,
    output logic o_irq_pending
);
    import phyies_pkg::*;

    // Address decode: word aligned and index match
    function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] addr,
                                     input logic [IDX_W-1:0] idx);
        reg_hit = (addr[BYTE_SHIFT-1:0] == '0) && (addr[AXI_ADDR_W-1:BYTE_SHIFT] == idx);
    endfunction : reg_hit

    // Byte lanes 0 and 1 cover the 16-bit registers; upper lanes are ignored
    function automatic logic [REG_W-1:0] lane_mask(input logic [DATA_W/8-1:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // Write path state
    logic aw_held_reg;
    logic aw_held_next;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_next;
    logic w_held_reg;
    logic w_held_next;
    phyies_wdata_t w_reg;
    phyies_wdata_t w_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;

    // Software registers
    logic [REG_W-1:0] enable_reg;
    logic [REG_W-1:0] enable_next;
    logic active_low_reg;
    logic active_low_next;

    // Read path state
    logic rvalid_reg;
    logic rvalid_next;
    phyies_rdata_t r_reg;
    phyies_rdata_t r_next;

    // Status and interrupt state
    logic pol_reg;
    logic pol_next;
    logic jab_reg;
    logic jab_next;
    logic irq_pin_reg;
    logic irq_pin_next;
    logic pending_reg;
    logic pending_next;

    logic [REG_W-1:0] flags;
    logic [REG_W-1:0] flag_clear;
    logic [REG_W-1:0] event_set;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    logic [REG_W-1:0] wmask;
    logic [REG_W-1:0] wdata16;
    logic [REG_W-1:0] quick_view;
    logic [REG_W-1:0] config_view;
    logic [REG_W-1:0] rd_word;
    logic rd_hit;
    logic rd_is_status;
    logic any_enabled_pending;

    assign o_awready = ~aw_held_reg & ~bvalid_reg;
    assign o_wready = ~w_held_reg & ~bvalid_reg;
    assign o_arready = ~rvalid_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_rvalid = rvalid_reg;
    assign o_r = r_reg;
    assign o_irq_pin = irq_pin_reg;
    assign o_irq_pending = pending_reg;

    assign aw_fire = i_awvalid & o_awready;
    assign w_fire = i_wvalid & o_wready;
    assign ar_fire = i_arvalid & o_arready;
    // Write is committed once both halves are held, in whichever order they came
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

    // Write channel handling
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_next = w_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (aw_fire) begin
            aw_held_next = 1'b1;
            aw_addr_next = i_aw.addr;
        end
        if (w_fire) begin
            w_held_next = 1'b1;
            w_next = i_w;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            if (reg_hit(aw_addr_reg, IDX_QUICK_STATUS) || reg_hit(aw_addr_reg, IDX_IRQ_ENABLE)
                || reg_hit(aw_addr_reg, IDX_IRQ_STATUS) || reg_hit(aw_addr_reg, IDX_IRQ_CONFIG)) begin
                bresp_next = RESP_OKAY;
            end else begin
                bresp_next = RESP_SLVERR;
            end
        end else if (bvalid_reg && i_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_reg <= w_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // Enable and config registers
    assign wmask = lane_mask(w_reg.strb);
    assign wdata16 = w_reg.data[REG_W-1:0];

    // Writes to the quick status and event status registers are ignored
    always_comb begin
        enable_next = enable_reg;
        active_low_next = active_low_reg;
        if (do_write && reg_hit(aw_addr_reg, IDX_IRQ_ENABLE)) begin
            // Reserved bits 9 and 7 stay zero
            enable_next = ((enable_reg & ~wmask) | (wdata16 & wmask))
                & EVENT_IMPL_MASK;
        end
        if (do_write && reg_hit(aw_addr_reg, IDX_IRQ_CONFIG)
            && wmask[CFG_BIT_IRQ_ACTIVE_LOW]) begin
            active_low_next = wdata16[CFG_BIT_IRQ_ACTIVE_LOW];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            enable_reg <= ENABLE_RST;
            active_low_reg <= IRQ_ACTIVE_LOW_RST;
        end else begin
            enable_reg <= enable_next;
            active_low_reg <= active_low_next;
        end
    end

    // Latched event flags
    // Events latch regardless of their enable bits
    assign event_set = i_event_pulse & EVENT_IMPL_MASK;
    // Only the bits returned as one by this read are cleared
    assign flag_clear = (ar_fire && rd_is_status) ? flags : '0;

    phyies_flag_bank #(
        .WIDTH(REG_W),
        .IMPL_MASK(EVENT_IMPL_MASK)
    ) u_flags (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(event_set),
        .i_clear(flag_clear),
        .o_flags(flags)
    );

    // Quick status sampling
    // Sampled copies; reading does not disturb them
    always_comb begin
        pol_next = i_pol_correct;
        jab_next = i_jabber_detect;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pol_reg <= POLARITY_RST;
            jab_reg <= JABBER_RST;
        end else begin
            pol_reg <= pol_next;
            jab_reg <= jab_next;
        end
    end

    // Read channel handling
    always_comb begin
        quick_view = '0;
        quick_view[QS_BIT_POLARITY] = pol_reg;
        quick_view[QS_BIT_JABBER] = jab_reg;
        config_view = '0;
        config_view[CFG_BIT_IRQ_ACTIVE_LOW] = active_low_reg;
    end

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        rd_is_status = 1'b0;
        if (reg_hit(i_ar.addr, IDX_QUICK_STATUS)) begin
            rd_word = quick_view;
        end else if (reg_hit(i_ar.addr, IDX_IRQ_ENABLE)) begin
            rd_word = enable_reg;
        end else if (reg_hit(i_ar.addr, IDX_IRQ_STATUS)) begin
            rd_word = flags;
            rd_is_status = 1'b1;
        end else if (reg_hit(i_ar.addr, IDX_IRQ_CONFIG)) begin
            rd_word = config_view;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        r_next = r_reg;
        if (ar_fire) begin
            rvalid_next = 1'b1;
            r_next.data = {{(DATA_W-REG_W){1'b0}}, rd_word};
            r_next.resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && i_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rvalid_reg <= 1'b0;
            r_reg <= '0;
        end else begin
            rvalid_reg <= rvalid_next;
            r_reg <= r_next;
        end
    end

    // Interrupt output
    // Level output: stays up until every enabled flag is read away or has its enable bit written to zero
    assign any_enabled_pending = |(flags & enable_reg);

    always_comb begin
        pending_next = any_enabled_pending;
        // Pin is driven low for pending when the active-low option is set
        irq_pin_next = any_enabled_pending ^ active_low_reg;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pending_reg <= 1'b0;
            irq_pin_reg <= IRQ_ACTIVE_LOW_RST;
        end else begin
            pending_reg <= pending_next;
            irq_pin_reg <= irq_pin_next;
        end
    end
endmodule : phyies_top

// File: test/phyies_checker.sv
// Port-level assertions for the interrupt enable and status block
`timescale 1ns/10ps
module phyies_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire phyies_pkg::phyies_rdata_t o_r,
    input wire logic [phyies_pkg::REG_W-1:0] i_event_pulse,
    input wire logic o_irq_pin,
    input wire logic o_irq_pending
);
    import phyies_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer missing");
    chk_rd_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_r))
        else $error("read answer not held");
    chk_wr_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |=> !o_bvalid ##1 o_bvalid) else $error("write answer off time");
    chk_wr_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while answering");
    chk_rd_refuse: assert property (o_rvalid |-> !o_arready)
        else $error("read taken while answering");
    chk_rsvd_zero: assert property (o_rvalid |-> o_r.data[31:16] == 16'h0000
        && !o_r.data[9] && !o_r.data[7]) else $error("reserved bit set");
    // A rise needs a fresh event or an enable write just before
    chk_irq_cause: assert property ($rose(o_irq_pending) |->
        $past(i_event_pulse, 2) != 16'h0000 || $past(o_bvalid)) else $error("irq without cause");
    chk_irq_clear: assert property ($fell(o_irq_pending) |->
        $past(o_rvalid) || $past(o_bvalid)) else $error("irq dropped without access");
    chk_pin_follow: assert property ($changed(o_irq_pin) |->
        $changed(o_irq_pending) || $past(o_bvalid)) else $error("pin moved alone");
endmodule : phyies_checker

bind phyies_top phyies_checker i_phyies_checker (.i_clk, .i_rst, .i_awvalid, .o_awready,
    .i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_r,
    .i_event_pulse, .o_irq_pin, .o_irq_pending);

// File: test/phyies_host_model.sv
// Management host model issuing single AXI4-Lite transfers on request
`timescale 1ns/10ps
module phyies_host_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_write,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_data,
    input wire logic [3:0] i_strb,
    output logic o_done = 1'b0,
    output logic [31:0] o_rdata = 32'h0,
    output logic [1:0] o_resp = 2'h0,
    output logic o_awvalid = 1'b0,
    input wire logic i_awready,
    output phyies_pkg::phyies_addr_t o_aw = '0,
    output logic o_wvalid = 1'b0,
    input wire logic i_wready,
    output phyies_pkg::phyies_wdata_t o_w = '0,
    input wire logic i_bvalid,
    output logic o_bready = 1'b0,
    input wire logic [1:0] i_bresp,
    output logic o_arvalid = 1'b0,
    input wire logic i_arready,
    output phyies_pkg::phyies_addr_t o_ar = '0,
    input wire logic i_rvalid,
    output logic o_rready = 1'b0,
    input wire phyies_pkg::phyies_rdata_t i_r
);
    import phyies_pkg::*;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_done <= 1'b0;
            o_awvalid <= 1'b0;
            o_wvalid <= 1'b0;
            o_bready <= 1'b0;
            o_arvalid <= 1'b0;
            o_rready <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_go && i_write) begin
                o_awvalid <= 1'b1;
                o_wvalid <= 1'b1;
                o_bready <= 1'b1;
                o_aw <= '{addr: i_addr, prot: 3'h0};
                o_w <= '{data: i_data, strb: i_strb};
            end
            if (i_go && !i_write) begin
                o_arvalid <= 1'b1;
                o_rready <= 1'b1;
                o_ar <= '{addr: i_addr, prot: 3'h0};
            end
            // Released payload is inverted so a stale value cannot pass
            if (o_awvalid && i_awready) begin
                o_awvalid <= 1'b0;
                o_aw.addr <= ~o_aw.addr;
            end
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_w.data <= ~o_w.data;
            end
            if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
                o_ar.addr <= ~o_ar.addr;
            end
            if (o_bready && i_bvalid) begin
                o_bready <= 1'b0;
                o_resp <= i_bresp;
                o_done <= 1'b1;
            end
            if (o_rready && i_rvalid) begin
                o_rready <= 1'b0;
                o_rdata <= i_r.data;
                o_resp <= i_r.resp;
                o_done <= 1'b1;
            end
        end
    end
endmodule : phyies_host_model

// File: test/tb_top.sv
// Self-checking bench for the interrupt enable and status block
`timescale 1ns/10ps
module tb_top;
    import phyies_pkg::*;
    localparam logic [7:0] A_QS = {IDX_QUICK_STATUS, 2'b00};
    localparam logic [7:0] A_EN = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [7:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_CF = {IDX_IRQ_CONFIG, 2'b00};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_pol_correct = 1'b1;
    logic i_jabber_detect = 1'b0;
    logic [REG_W-1:0] i_event_pulse = '0;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] strb = 4'hF;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, done;
    logic i_arvalid, o_arready, o_rvalid, i_rready, o_irq_pin, o_irq_pending;
    logic [1:0] o_bresp, resp;
    logic [31:0] rd, v;
    logic [15:0] e;
    phyies_addr_t i_aw, i_ar;
    phyies_wdata_t i_w;
    phyies_rdata_t o_r;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    integer seed = 32'h00A20026;
    always #25 i_clk = ~i_clk;
    phyies_top i_phyies_top (.i_clk, .i_rst, .i_awvalid, .o_awready, .i_aw, .i_wvalid,
        .o_wready, .i_w, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_ar,
        .o_rvalid, .i_rready, .o_r, .i_event_pulse, .i_pol_correct, .i_jabber_detect,
        .o_irq_pin, .o_irq_pending);
    phyies_host_model i_phyies_host_model (.i_clk, .i_rst, .i_go(go), .i_write(wr),
        .i_addr(addr), .i_data(wdata), .i_strb(strb),
        .o_done(done), .o_rdata(rd), .o_resp(resp),
        .o_awvalid(i_awvalid), .i_awready(o_awready), .o_aw(i_aw), .o_wvalid(i_wvalid),
        .i_wready(o_wready), .o_w(i_w), .i_bvalid(o_bvalid), .o_bready(i_bready),
        .i_bresp(o_bresp), .o_arvalid(i_arvalid), .i_arready(o_arready), .o_ar(i_ar),
        .i_rvalid(o_rvalid), .o_rready(i_rready), .i_r(o_r));
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        go <= 1'b1;
        wr <= w_en;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 40) bad_count++;
    endtask : bus
    task automatic pulse(input logic [15:0] m);
        @(posedge i_clk);
        i_event_pulse <= m;
        @(posedge i_clk);
        i_event_pulse <= 16'h0000;
    endtask : pulse
    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask : settle
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(0, A_EN, 0);
        check_val("enable rst", 0, rd);
        bus(0, A_ST, 0);
        check_val("status rst", 0, rd);
        bus(0, A_QS, 0);
        check_val("quick rst", 32'h2, rd);
        bus(0, A_CF, 0);
        check_val("config rst", 32'h2000, rd);
        check_val("pin idle", 1, o_irq_pin);
        $display("test reset done");
        for (int b = 0; b < 16; b++) begin
            e = (16'h0001 << b) & EVENT_IMPL_MASK;
            bus(1, A_EN, 0);
            pulse(16'h0001 << b);
            bus(0, A_ST, 0);
            check_val("flag", e, rd);
            check_val("pend masked", 0, o_irq_pending);
            bus(0, A_ST, 0);
            check_val("flag cleared", 0, rd);
            bus(1, A_EN, 32'h1 << b);
            bus(0, A_EN, 0);
            check_val("enable", e, rd);
            pulse(16'h0001 << b);
            settle();
            check_val("pend on", |e, o_irq_pending);
            check_val("pin on", ~|e, o_irq_pin);
            bus(0, A_ST, 0);
            check_val("pend off", 0, o_irq_pending);
        end
        $display("test per event done");
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            bus(1, A_EN, v);
            bus(0, A_EN, 0);
            check_val("enable rand", v[15:0] & EVENT_IMPL_MASK, rd);
            @(posedge i_clk);
            i_pol_correct <= v[0];
            i_jabber_detect <= v[1];
            pulse(v[15:0]);
            pulse(v[31:16]);
            bus(0, A_ST, 0);
            check_val("flags rand", (v[15:0] | v[31:16]) & EVENT_IMPL_MASK, rd);
            repeat (2) begin
                bus(0, A_QS, 0);
                check_val("quick", {v[0], v[1]}, rd);
            end
        end
        $display("test random done");
        bus(1, A_EN, 32'h1);
        bus(0, A_ST, 0);
        bus(1, A_CF, 0);
        settle();
        check_val("pin high idle", 0, o_irq_pin);
        pulse(16'h0001);
        settle();
        check_val("pin high on", 1, o_irq_pin);
        bus(0, A_ST, 0);
        check_val("pin high off", 0, o_irq_pin);
        $display("test polarity done");
        // An event in the clearing read's handshake cycle must survive that read
        pulse(16'h0400);
        fork
            bus(0, A_ST, 0);
            begin
                repeat (2) @(posedge i_clk);
                i_event_pulse <= 16'h0400;
                @(posedge i_clk);
                i_event_pulse <= 16'h0000;
            end
        join
        check_val("flag at clear", 32'h0400, rd);
        bus(0, A_ST, 0);
        check_val("flag kept", 32'h0400, rd);
        $display("test clear race done");
        strb <= 4'h1;
        bus(1, A_EN, 32'hFFFF);
        strb <= 4'hF;
        bus(0, A_EN, 0);
        check_val("enable lane0", 32'h007F, rd);
        bus(1, A_ST, 32'hFFFF);
        check_val("ro write bresp", RESP_OKAY, resp);
        bus(0, A_ST, 0);
        check_val("ro write ignored", 0, rd);
        bus(0, 8'h49, 0);
        check_val("unaligned rresp", RESP_SLVERR, resp);
        $display("test lanes done");
        bus(0, 8'h3C, 0);
        check_val("unmapped rd", 0, rd);
        check_val("unmapped rresp", RESP_SLVERR, resp);
        bus(1, 8'h3C, 32'hFFFF);
        check_val("unmapped bresp", RESP_SLVERR, resp);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule : tb_top
